// ==== hw/lic_pkg.sv ====
// Purpose: Shared constants and types for the line interface control block.
// Assumes: Four channels and a 100 MHz master clock.
// Notes: Field codes below are the line-side control encodings.
package lic_pkg;
  localparam int NCH = 4;
  localparam int CLK_PERIOD_NS = 10;
  // Transmit clock counts as lost after this long without an edge.
  localparam int TXCLK_LOSS_NS = 2000;
  localparam int TXCLK_LOSS_CYC = (TXCLK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOSS_CNT_W = 8;
  localparam logic [LOSS_CNT_W-1:0] LOSS_LIMIT = LOSS_CNT_W'(TXCLK_LOSS_CYC);
  // Termination codes; the top bit selects external matching.
  localparam logic [2:0] TERM_E1_75 = 3'h0;
  localparam logic [2:0] TERM_E1_120 = 3'h1;
  localparam logic [2:0] TERM_T1 = 3'h2;
  localparam logic [2:0] TERM_J1 = 3'h3;
  localparam int TERM_EXT_BIT = 2;
  // Pulse template codes run from 0 up to the last build-out case.
  localparam logic [3:0] PULSE_MAX = 4'hb;
  localparam logic [3:0] PULSE_RST = 4'h0;
  // Monitor boost: 0 = 0 dB, 1 = 22 dB, 2 = 26 dB, 3 = 32 dB.
  localparam logic [1:0] BOOST_RST = 2'h0;
  // Observation period: 0 = 32, 1 = 64, 2 = 128, 3 = 256 symbols.
  localparam logic [1:0] OBS_RST = 2'h2;
  // Decision threshold: 0 = 40, 1 = 50, 2 = 60, 3 = 70 percent.
  localparam logic [1:0] THR_RST = 2'h1;
  localparam int RAIL_BIT = 1;
  localparam int ZS_BIT = 0;
  localparam logic [1:0] MODE_BYPASS = 2'h3;
  localparam int LOSS_W = 5;
  typedef enum logic [1:0] {
    LIC_DEC_AMI = 2'b00,
    LIC_DEC_B8ZS = 2'b01,
    LIC_DEC_HDB3 = 2'b10
  } lic_decoder_t;
endpackage : lic_pkg

// ==== hw/lic_eq_irq.sv ====
// Purpose: Equalizer range status tracking and its interrupt flag.
// Assumes: The status input is already synchronised to clk.
// Notes: A set in the same cycle as a read keeps the flag.
`timescale 1ns/1ps
module lic_eq_irq (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic status_in,
  input wire logic edge_select,
  input wire logic flag_read,
  input wire logic irq_mask,
  output logic status_q,
  output logic flag_q,
  output wire logic irq
);
  logic flag_d;
  wire any_change = status_in ^ status_q;
  wire rise = status_in & ~status_q;
  wire flag_set = edge_select ? any_change : rise;
  assign flag_d = flag_set | (flag_q & ~flag_read);
  assign irq = flag_q & ~irq_mask;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      status_q <= status_in;
      flag_q <= flag_d;
    end
  end
endmodule : lic_eq_irq

// ==== hw/lic_rx_path.sv ====
// Purpose: Receive decoder selection, rail mapping and recovery bypass.
// Assumes: Slicer inputs are synchronised; recovery and decoder inputs are on clk.
// Notes: All data outputs, and the receive clock, come from flip-flops.
`timescale 1ns/1ps
module lic_rx_path (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] rx_decode_mode,
  input wire logic t1j1_mode,
  input wire logic slicer_pos,
  input wire logic slicer_neg,
  input wire logic cdr_pos,
  input wire logic cdr_neg,
  input wire logic cdr_clock,
  input wire logic dec_data,
  input wire logic dec_code_err,
  output logic rx_data_pos,
  output logic rx_data_neg,
  output logic rx_clock_out,
  output lic_pkg::lic_decoder_t decoder_select,
  output wire logic cdr_bypass
);
  logic pos_d;
  logic neg_d;
  logic clk_d;
  wire dual_rail = rx_decode_mode[lic_pkg::RAIL_BIT];
  assign cdr_bypass = (rx_decode_mode == lic_pkg::MODE_BYPASS);
  wire zs_code = rx_decode_mode[lic_pkg::ZS_BIT];
  wire lic_pkg::lic_decoder_t zs_kind = t1j1_mode ? lic_pkg::LIC_DEC_B8ZS : lic_pkg::LIC_DEC_HDB3;
  wire lic_pkg::lic_decoder_t dec_d = zs_code ? zs_kind : lic_pkg::LIC_DEC_AMI;
  // Single rail carries data on one pin and code errors on the other.
  assign pos_d = cdr_bypass ? slicer_pos : (dual_rail ? cdr_pos : dec_data);
  assign neg_d = cdr_bypass ? slicer_neg : (dual_rail ? cdr_neg : dec_code_err);
  // The recovered clock passes through so its phase to the data is kept.
  assign clk_d = cdr_bypass ? (slicer_pos ^ slicer_neg) : cdr_clock;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_data_pos <= 1'b0;
      rx_data_neg <= 1'b0;
      rx_clock_out <= 1'b0;
      decoder_select <= lic_pkg::LIC_DEC_AMI;
    end else begin
      rx_data_pos <= pos_d;
      rx_data_neg <= neg_d;
      rx_clock_out <= clk_d;
      decoder_select <= dec_d;
    end
  end
endmodule : lic_rx_path

// ==== hw/lic_top.sv ====
// Purpose: Per-channel line-side control and status for four line channels.
// Assumes: clk is the master clock; analog status and pins are asynchronous.
// Notes: Control fields are plain ports; there is no register bus.
`timescale 1ns/1ps
// What this block does
// - Transmit termination codes 000..011 and pulse template codes 0000..1011.
// - Transmit termination top bit selects external matching, refused in T1/J1 mode.
// - Receive termination codes 000..011; top bit set disables internal matching.
// - Global tristate pin or per-channel bit floats transmit outputs; circuits keep running.
// - Lost master clock floats transmit outputs of every channel.
// - Lost transmit clock floats that channel, except remote loopback or internal pattern.
// - Transmit outputs float after software reset, pin reset and power-on.
// - Transmit power-down powers off that channel only and floats its outputs.
// - Two-bit monitor boost selects 0, 22, 26 or 32 dB.
// - Equalizer enable bit switches the adaptive equalizer on or off.
// - Equalizer status reads one while the equalizer is out of range.
// - With edge select one, any status change sets the equalizer flag.
// - With edge select zero, only a rising status change sets the flag.
// - Reading the equalizer flag clears it.
// - Observation period 32, 64, 128 or 256 symbols; 128 after reset.
// - Five-bit read-only cable loss level, about 2 dB per step.
// - Two-bit slicer threshold selects 40, 50, 60 or 70 percent.
// - Recovery bypass only in dual rail; slicer then drives receive data pins.
// - Recovered receive clock follows data jitter and holds phase without pulses.
// - Decode mode picks AMI or B8ZS in T1/J1, AMI or HDB3 in E1.
// - Decode mode bit one picks single or dual rail; single carries code errors.
// - Decode mode 11 bypasses recovery; receive clock is XOR of both rails.
module lic_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic soft_reset,
  input wire logic t1j1_mode,
  input wire logic tx_tristate_pin,
  input wire logic mclk_loss_ind,
  input wire logic [lic_pkg::NCH-1:0] tx_tristate,
  input wire logic [lic_pkg::NCH-1:0] tx_power_down,
  input wire logic [lic_pkg::NCH-1:0] remote_loop,
  input wire logic [lic_pkg::NCH-1:0] tx_pattern_mclk,
  input wire logic [lic_pkg::NCH-1:0][2:0] tx_term_select,
  input wire logic [lic_pkg::NCH-1:0][3:0] pulse_template_select,
  input wire logic [lic_pkg::NCH-1:0] tx_clock,
  input wire logic [lic_pkg::NCH-1:0] tx_data_pos,
  input wire logic [lic_pkg::NCH-1:0] tx_data_neg,
  input wire logic [lic_pkg::NCH-1:0][2:0] rx_term_select,
  input wire logic [lic_pkg::NCH-1:0][1:0] monitor_boost_select,
  input wire logic [lic_pkg::NCH-1:0] equalizer_enable,
  input wire logic [lic_pkg::NCH-1:0][1:0] observation_period_select,
  input wire logic [lic_pkg::NCH-1:0][1:0] decision_threshold_select,
  input wire logic [lic_pkg::NCH-1:0][1:0] rx_decode_mode,
  input wire logic [lic_pkg::NCH-1:0] eq_out_of_range,
  input wire logic [lic_pkg::NCH-1:0] equalizer_edge_select,
  input wire logic [lic_pkg::NCH-1:0] eq_irq_mask,
  input wire logic [lic_pkg::NCH-1:0] eq_flag_read,
  input wire logic [lic_pkg::NCH-1:0][lic_pkg::LOSS_W-1:0] cable_loss_raw,
  input wire logic [lic_pkg::NCH-1:0] slicer_pos,
  input wire logic [lic_pkg::NCH-1:0] slicer_neg,
  input wire logic [lic_pkg::NCH-1:0] cdr_pos,
  input wire logic [lic_pkg::NCH-1:0] cdr_neg,
  input wire logic [lic_pkg::NCH-1:0] cdr_clock,
  input wire logic [lic_pkg::NCH-1:0] dec_data,
  input wire logic [lic_pkg::NCH-1:0] dec_code_err,
  output logic [lic_pkg::NCH-1:0] tx_line_pos,
  output logic [lic_pkg::NCH-1:0] tx_line_neg,
  output logic [lic_pkg::NCH-1:0] tx_line_oe_b,
  output logic [lic_pkg::NCH-1:0] tx_path_off,
  output logic [lic_pkg::NCH-1:0] tx_clock_lost,
  output logic [lic_pkg::NCH-1:0] tx_int_term_en,
  output logic [lic_pkg::NCH-1:0][1:0] tx_term_code,
  output logic [lic_pkg::NCH-1:0][3:0] pulse_template_q,
  output logic [lic_pkg::NCH-1:0] rx_int_term_en,
  output logic [lic_pkg::NCH-1:0][1:0] rx_term_code,
  output logic [lic_pkg::NCH-1:0][1:0] monitor_boost_q,
  output logic [lic_pkg::NCH-1:0] equalizer_on,
  output logic [lic_pkg::NCH-1:0][1:0] observation_period_q,
  output logic [lic_pkg::NCH-1:0][1:0] decision_threshold_q,
  output logic [lic_pkg::NCH-1:0] equalizer_range_status,
  output logic [lic_pkg::NCH-1:0] equalizer_irq_flag,
  output wire logic [lic_pkg::NCH-1:0] eq_irq,
  output logic [lic_pkg::NCH-1:0][lic_pkg::LOSS_W-1:0] cable_loss_level,
  output logic [lic_pkg::NCH-1:0] rx_data_pos,
  output logic [lic_pkg::NCH-1:0] rx_data_neg,
  output logic [lic_pkg::NCH-1:0] rx_clock_out,
  output lic_pkg::lic_decoder_t [lic_pkg::NCH-1:0] decoder_select,
  output wire logic [lic_pkg::NCH-1:0] cdr_bypass
);
  // Global asynchronous inputs pass two flip-flops first.
  logic pin_meta_q;
  logic pin_sync_q;
  logic mloss_meta_q;
  logic mloss_sync_q;
  // The pin synchroniser starts at the floating level, so the lines stay quiet until sampled.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
    end else begin
      pin_meta_q <= tx_tristate_pin;
      pin_sync_q <= pin_meta_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mloss_meta_q <= 1'b0;
      mloss_sync_q <= 1'b0;
    end else begin
      mloss_meta_q <= mclk_loss_ind;
      mloss_sync_q <= mloss_meta_q;
    end
  end

  // Floats every channel at once.
  wire global_hiz = pin_sync_q | mloss_sync_q | soft_reset;

  genvar ch;
  generate
    for (ch = 0; ch < lic_pkg::NCH; ch++) begin : g_ch
      logic tclk_meta_q;
      logic tclk_sync_q;
      logic tclk_prev_q;
      logic [lic_pkg::LOSS_CNT_W-1:0] idle_cnt_q;
      logic [lic_pkg::LOSS_CNT_W-1:0] idle_cnt_d;
      logic lost_q;
      logic hiz_q;
      logic eq_meta_q;
      logic eq_sync_q;
      logic sp_meta_q;
      logic sp_sync_q;
      logic sn_meta_q;
      logic sn_sync_q;
      logic [lic_pkg::LOSS_W-1:0] loss_meta_q;
      logic [lic_pkg::LOSS_W-1:0] loss_sync_q;
      logic [lic_pkg::LOSS_W-1:0] loss_prev_q;
      logic [3:0] pulse_d;

      // Transmit clock watchdog: counts master cycles since the last edge.
      // The idle counter saturates, so a stopped clock keeps the loss flag without wrapping.
      wire tclk_edge = tclk_sync_q ^ tclk_prev_q;
      wire idle_full = (idle_cnt_q == lic_pkg::LOSS_LIMIT);
      assign idle_cnt_d = tclk_edge ? '0 :
                          (idle_full ? idle_cnt_q : idle_cnt_q + 1'b1);
      wire lost_d = ~tclk_edge & (idle_full | lost_q);

      // Loopback and master-timed patterns do not need the transmit clock.
      wire tclk_hiz = lost_q & ~remote_loop[ch] & ~tx_pattern_mclk[ch];
      wire hiz_d = global_hiz | tx_tristate[ch] | tx_power_down[ch] | tclk_hiz;

      // External transmit matching is refused in T1/J1 mode.
      wire tx_ext = tx_term_select[ch][lic_pkg::TERM_EXT_BIT] & ~t1j1_mode;
      // Template codes past the last build-out case are ignored.
      wire pulse_ok = (pulse_template_select[ch] <= lic_pkg::PULSE_MAX);
      assign pulse_d = pulse_ok ? pulse_template_select[ch] : pulse_template_q[ch];
      // The loss word crosses bit by bit, so it is taken only after two equal samples.
      wire loss_stable = (loss_sync_q == loss_prev_q);
      wire [lic_pkg::LOSS_W-1:0] loss_d = loss_stable ? loss_sync_q : cable_loss_level[ch];

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          tclk_meta_q <= 1'b0;
          tclk_sync_q <= 1'b0;
          tclk_prev_q <= 1'b0;
        end else begin
          tclk_meta_q <= tx_clock[ch];
          tclk_sync_q <= tclk_meta_q;
          tclk_prev_q <= tclk_sync_q;
        end
      end

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          eq_meta_q <= 1'b0;
          eq_sync_q <= 1'b0;
        end else begin
          eq_meta_q <= eq_out_of_range[ch];
          eq_sync_q <= eq_meta_q;
        end
      end

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          sp_meta_q <= 1'b0;
          sp_sync_q <= 1'b0;
          sn_meta_q <= 1'b0;
          sn_sync_q <= 1'b0;
        end else begin
          sp_meta_q <= slicer_pos[ch];
          sp_sync_q <= sp_meta_q;
          sn_meta_q <= slicer_neg[ch];
          sn_sync_q <= sn_meta_q;
        end
      end

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          loss_meta_q <= '0;
          loss_sync_q <= '0;
          loss_prev_q <= '0;
        end else begin
          loss_meta_q <= cable_loss_raw[ch];
          loss_sync_q <= loss_meta_q;
          loss_prev_q <= loss_sync_q;
        end
      end

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          idle_cnt_q <= '0;
          lost_q <= 1'b0;
          hiz_q <= 1'b1;
        end else begin
          idle_cnt_q <= idle_cnt_d;
          lost_q <= lost_d;
          hiz_q <= hiz_d;
        end
      end

      // Data keeps flowing while floated, so the transmit circuits stay active.
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          tx_line_pos[ch] <= 1'b0;
          tx_line_neg[ch] <= 1'b0;
        end else begin
          tx_line_pos[ch] <= tx_data_pos[ch];
          tx_line_neg[ch] <= tx_data_neg[ch];
        end
      end

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          tx_line_oe_b[ch] <= 1'b1;
          tx_path_off[ch] <= 1'b0;
          tx_clock_lost[ch] <= 1'b0;
        end else begin
          tx_line_oe_b[ch] <= hiz_q;
          tx_path_off[ch] <= tx_power_down[ch];
          tx_clock_lost[ch] <= lost_q;
        end
      end

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          tx_int_term_en[ch] <= 1'b1;
          tx_term_code[ch] <= lic_pkg::TERM_E1_75[1:0];
          pulse_template_q[ch] <= lic_pkg::PULSE_RST;
          rx_int_term_en[ch] <= 1'b1;
          rx_term_code[ch] <= lic_pkg::TERM_E1_75[1:0];
        end else begin
          tx_int_term_en[ch] <= ~tx_ext;
          tx_term_code[ch] <= tx_term_select[ch][1:0];
          pulse_template_q[ch] <= pulse_d;
          rx_int_term_en[ch] <= ~rx_term_select[ch][lic_pkg::TERM_EXT_BIT];
          rx_term_code[ch] <= rx_term_select[ch][1:0];
        end
      end

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          monitor_boost_q[ch] <= lic_pkg::BOOST_RST;
          equalizer_on[ch] <= 1'b0;
          observation_period_q[ch] <= lic_pkg::OBS_RST;
          decision_threshold_q[ch] <= lic_pkg::THR_RST;
          cable_loss_level[ch] <= '0;
        end else begin
          monitor_boost_q[ch] <= monitor_boost_select[ch];
          equalizer_on[ch] <= equalizer_enable[ch];
          observation_period_q[ch] <= observation_period_select[ch];
          decision_threshold_q[ch] <= decision_threshold_select[ch];
          cable_loss_level[ch] <= loss_d;
        end
      end

      lic_eq_irq u_eq (
        .clk(clk),
        .rst_b(rst_b),
        .status_in(eq_sync_q),
        .edge_select(equalizer_edge_select[ch]),
        .flag_read(eq_flag_read[ch]),
        .irq_mask(eq_irq_mask[ch]),
        .status_q(equalizer_range_status[ch]),
        .flag_q(equalizer_irq_flag[ch]),
        .irq(eq_irq[ch])
      );

      lic_rx_path u_rx (
        .clk(clk),
        .rst_b(rst_b),
        .rx_decode_mode(rx_decode_mode[ch]),
        .t1j1_mode(t1j1_mode),
        .slicer_pos(sp_sync_q),
        .slicer_neg(sn_sync_q),
        .cdr_pos(cdr_pos[ch]),
        .cdr_neg(cdr_neg[ch]),
        .cdr_clock(cdr_clock[ch]),
        .dec_data(dec_data[ch]),
        .dec_code_err(dec_code_err[ch]),
        .rx_data_pos(rx_data_pos[ch]),
        .rx_data_neg(rx_data_neg[ch]),
        .rx_clock_out(rx_clock_out[ch]),
        .decoder_select(decoder_select[ch]),
        .cdr_bypass(cdr_bypass[ch])
      );
    end
  endgenerate
endmodule : lic_top

// ==== tb/lic_top_asserts.sv ====
// Purpose: Port-level timing checks for the line interface control block.
// Assumes: Bound to lic_top; every check runs on clk.
// Notes: Channel zero carries most checks; channel three the bypass, matching and template ones.
`timescale 1ns/1ps
module lic_top_chk #(
  parameter int N = lic_pkg::NCH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic soft_reset,
  input wire logic t1j1_mode,
  input wire logic tx_tristate_pin,
  input wire logic mclk_loss_ind,
  input wire logic [N-1:0] tx_tristate,
  input wire logic [N-1:0] tx_power_down,
  input wire logic [N-1:0][2:0] tx_term_select,
  input wire logic [N-1:0][3:0] pulse_template_select,
  input wire logic [N-1:0][1:0] rx_decode_mode,
  input wire logic [N-1:0] equalizer_edge_select,
  input wire logic [N-1:0] eq_flag_read,
  input wire logic [N-1:0] dec_code_err,
  input wire logic [N-1:0] tx_line_oe_b,
  input wire logic [N-1:0] tx_clock_lost,
  input wire logic [N-1:0] tx_int_term_en,
  input wire logic [N-1:0][3:0] pulse_template_q,
  input wire logic [N-1:0] equalizer_range_status,
  input wire logic [N-1:0] equalizer_irq_flag,
  input wire logic [N-1:0] rx_data_pos,
  input wire logic [N-1:0] rx_data_neg,
  input wire logic [N-1:0] rx_clock_out,
  input lic_pkg::lic_decoder_t [N-1:0] decoder_select,
  input wire logic [N-1:0] cdr_bypass
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // No float cause at all, including a lost transmit clock.
  wire quiet = !tx_tristate_pin && !mclk_loss_ind && !soft_reset && tx_tristate == '0 &&
    tx_power_down == '0 && tx_clock_lost == '0;
  a_chan_float: assert property (
    (tx_tristate[0] || tx_power_down[0]) [*3] |=> tx_line_oe_b[0])
    else $error("channel float missing");
  a_global_float: assert property (
    (tx_tristate_pin || mclk_loss_ind || soft_reset) [*4] |=> tx_line_oe_b == '1)
    else $error("global float missing");
  a_drive_quiet: assert property (quiet [*6] |=> tx_line_oe_b == '0)
    else $error("outputs floated with no cause");
  a_tx_ext_term: assert property (
    tx_term_select[3][2] |=> tx_int_term_en[3] == $past(t1j1_mode))
    else $error("external transmit matching wrong");
  a_pulse_hold: assert property (rst_b |=> pulse_template_q[3] ==
    (($past(pulse_template_select[3]) > lic_pkg::PULSE_MAX) ? $past(pulse_template_q[3]) :
    $past(pulse_template_select[3])))
    else $error("pulse template copy wrong");
  a_rise_flag: assert property ($rose(equalizer_range_status[0]) |-> equalizer_irq_flag[0])
    else $error("rising status did not set flag");
  a_fall_flag: assert property (
    $fell(equalizer_range_status[0]) && !$past(equalizer_irq_flag[0]) |->
    equalizer_irq_flag[0] == $past(equalizer_edge_select[0]))
    else $error("falling status flag wrong");
  a_read_clear: assert property (
    eq_flag_read[0] |=> !equalizer_irq_flag[0] || $changed(equalizer_range_status[0]))
    else $error("read did not clear flag");
  a_bypass_xor: assert property ((rx_decode_mode[3] == 2'h3) [*2] |-> cdr_bypass[3] &&
    rx_clock_out[3] == (rx_data_pos[3] ^ rx_data_neg[3]))
    else $error("bypass clock wrong");
  a_single_rail: assert property (
    (rx_decode_mode[0][1] == 1'b0) [*2] |-> rx_data_neg[0] == $past(dec_code_err[0]))
    else $error("code error rail wrong");
  a_decoder_sel: assert property (rst_b |=> decoder_select[0] ==
    ($past(rx_decode_mode[0][0]) ? ($past(t1j1_mode) ? lic_pkg::LIC_DEC_B8ZS :
    lic_pkg::LIC_DEC_HDB3) : lic_pkg::LIC_DEC_AMI))
    else $error("decoder select wrong");
  c_flag: cover property ($rose(equalizer_irq_flag[0]));
  c_bypass: cover property (cdr_bypass[3]);
  c_clk_lost: cover property ($rose(tx_clock_lost[0]));
endmodule : lic_top_chk
bind lic_top lic_top_chk u_chk (.*);

// ==== tb/lic_top_tb.sv ====
// Purpose: Self-checking bench for the line interface control block.
// Assumes: Inputs change at the falling clock edge.
// Notes: Transmit clocks toggle every cycle unless stopped per channel.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_b, soft_reset, t1j1_mode, tx_tristate_pin, mclk_loss_ind;
  logic [3:0] tx_tristate, tx_power_down, remote_loop, tx_pattern_mclk, tx_clock, tx_data_pos;
  logic [3:0] tx_data_neg, equalizer_enable, eq_out_of_range, equalizer_edge_select;
  logic [3:0] eq_irq_mask, eq_flag_read, slicer_pos, slicer_neg, cdr_pos, cdr_neg, cdr_clock;
  logic [3:0] dec_data, dec_code_err, tck_run;
  logic [3:0][2:0] tx_term_select, rx_term_select;
  logic [3:0][3:0] pulse_template_select, pulse_template_q;
  logic [3:0][1:0] monitor_boost_select, observation_period_select, decision_threshold_select;
  logic [3:0][1:0] rx_decode_mode, tx_term_code, rx_term_code, monitor_boost_q;
  logic [3:0][1:0] observation_period_q, decision_threshold_q;
  logic [3:0][4:0] cable_loss_raw, cable_loss_level;
  logic [3:0] tx_line_pos, tx_line_neg, tx_line_oe_b, tx_path_off, tx_clock_lost;
  logic [3:0] tx_int_term_en, rx_int_term_en, equalizer_on, equalizer_range_status;
  logic [3:0] equalizer_irq_flag, rx_data_pos, rx_data_neg, rx_clock_out;
  wire [3:0] eq_irq, cdr_bypass;
  lic_pkg::lic_decoder_t [3:0] decoder_select;
  int fails, n_tests;
  lic_top dut (.*);
  always #5 clk = ~clk;
  always @(negedge clk) tx_clock <= rst_b ? (tx_clock ^ tck_run) : '0;
  task cyc(input int n); repeat (n) @(negedge clk); endtask : cyc
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task t_reset;
    chk(tx_line_oe_b, 4'hf);
    chk(observation_period_q, {4{2'h2}});
    chk(decoder_select[0], lic_pkg::LIC_DEC_AMI);
    cyc(6);
    chk(tx_line_oe_b, 4'h0);
    $display("test reset done");
  endtask : t_reset
  task t_float;
    tx_tristate = 4'h2; tx_data_pos = 4'h5; tx_data_neg = 4'ha; cyc(4);
    chk(tx_line_oe_b, 4'h2);
    chk(tx_line_pos, 4'h5);
    chk(tx_line_neg, 4'ha);
    tx_tristate = 0; tx_power_down = 4'h4; cyc(4);
    chk(tx_line_oe_b, 4'h4);
    chk(tx_path_off, 4'h4);
    tx_power_down = 0; tx_tristate_pin = 1; cyc(5);
    chk(tx_line_oe_b, 4'hf);
    tx_tristate_pin = 0; mclk_loss_ind = 1; cyc(5);
    chk(tx_line_oe_b, 4'hf);
    mclk_loss_ind = 0; soft_reset = 1; cyc(5);
    chk(tx_line_oe_b, 4'hf);
    soft_reset = 0; cyc(6);
    chk(tx_line_oe_b, 4'h0);
    $display("test float done");
  endtask : t_float
  task t_txclk;
    tck_run = 4'h8; remote_loop = 4'h2; tx_pattern_mclk = 4'h4; cyc(150);
    chk(tx_line_oe_b, 4'h0);
    cyc(70);
    chk(tx_line_oe_b, 4'h1);
    chk(tx_clock_lost[0], 1'b1);
    tck_run = 4'hf; cyc(8);
    chk(tx_line_oe_b, 4'h0);
    remote_loop = 0; tx_pattern_mclk = 0;
    $display("test tx clock done");
  endtask : t_txclk
  task t_config;
    tx_term_select = {3'h4, 3'h3, 3'h1, 3'h2}; rx_term_select = {3'h4, 3'h3, 3'h1, 3'h2};
    pulse_template_select = {4'hb, 4'h7, 4'h0, 4'h1}; equalizer_enable = 4'h5;
    monitor_boost_select = {2'h3, 2'h2, 2'h1, 2'h0}; decision_threshold_select = {2'h0, 2'h3, 2'h2, 2'h1};
    observation_period_select = {2'h3, 2'h2, 2'h1, 2'h0}; cable_loss_raw = {5'h1f, 5'h10, 5'h1, 5'ha};
    t1j1_mode = 0; cyc(4);
    chk(tx_int_term_en, 4'h7);
    chk(tx_term_code, {2'h0, 2'h3, 2'h1, 2'h2});
    chk(rx_int_term_en, 4'h7);
    chk(rx_term_code, {2'h0, 2'h3, 2'h1, 2'h2});
    chk(pulse_template_q, {4'hb, 4'h7, 4'h0, 4'h1});
    chk(monitor_boost_q, {2'h3, 2'h2, 2'h1, 2'h0});
    chk(decision_threshold_q, {2'h0, 2'h3, 2'h2, 2'h1});
    chk(observation_period_q, {2'h3, 2'h2, 2'h1, 2'h0});
    chk(equalizer_on, 4'h5);
    chk(cable_loss_level, {5'h1f, 5'h10, 5'h1, 5'ha});
    t1j1_mode = 1; pulse_template_select[3] = 4'hc; cyc(2);
    chk(tx_int_term_en, 4'hf);
    chk(rx_int_term_en, 4'h7);
    chk(pulse_template_q[3], 4'hb);
    $display("test config done");
  endtask : t_config
  task t_eq;
    equalizer_edge_select = 4'h2; eq_irq_mask = 4'h2; eq_out_of_range = 4'h3; cyc(5);
    chk(equalizer_range_status, 4'h3);
    chk(equalizer_irq_flag, 4'h3);
    chk(eq_irq, 4'h1);
    eq_flag_read = 4'h3; cyc(1);
    eq_flag_read = 0; cyc(1);
    chk(equalizer_irq_flag, 4'h0);
    eq_out_of_range = 0; cyc(5);
    chk(equalizer_range_status, 4'h0);
    chk(equalizer_irq_flag, 4'h2);
    chk(eq_irq, 4'h0);
    eq_irq_mask = 0; cyc(1);
    chk(eq_irq, 4'h2);
    $display("test equalizer done");
  endtask : t_eq
  task t_rx;
    rx_decode_mode = {2'h3, 2'h2, 2'h1, 2'h0}; dec_data = 4'h2; dec_code_err = 4'h1;
    cdr_pos = 4'h4; cdr_clock = 4'h4; slicer_pos = 4'h8; cyc(5);
    chk(rx_clock_out, 4'hc);
    chk(rx_data_pos, 4'he);
    chk(rx_data_neg, 4'h1);
    chk(rx_clock_out[3], 1'b1);
    chk(cdr_bypass, 4'h8);
    chk(decoder_select[1], lic_pkg::LIC_DEC_B8ZS);
    cdr_pos = 0; cdr_neg = 4'h4; slicer_pos = 0; slicer_neg = 4'h8; cyc(5);
    chk(rx_data_pos, 4'h2);
    chk(rx_data_neg, 4'hd);
    slicer_pos = 4'h8; t1j1_mode = 0; cyc(5);
    chk(rx_clock_out[3], 1'b0);
    chk(decoder_select[1], lic_pkg::LIC_DEC_HDB3);
    chk(decoder_select[0], lic_pkg::LIC_DEC_AMI);
    $display("test receive done");
  endtask : t_rx
  initial begin
    {soft_reset, t1j1_mode, tx_tristate_pin, mclk_loss_ind, tx_tristate, tx_power_down} = '0;
    {remote_loop, tx_pattern_mclk, tx_data_pos, tx_data_neg, tx_term_select} = '0;
    {pulse_template_select, rx_term_select, monitor_boost_select, equalizer_enable} = '0;
    {observation_period_select, decision_threshold_select, rx_decode_mode} = '0;
    {eq_out_of_range, equalizer_edge_select, eq_irq_mask, eq_flag_read, cable_loss_raw} = '0;
    {slicer_pos, slicer_neg, cdr_pos, cdr_neg, cdr_clock, dec_data, dec_code_err} = '0;
    rst_b = 0; tck_run = 4'hf; fails = 0; n_tests = 0;
    cyc(3);
    rst_b = 1;
    t_reset;
    t_float;
    t_txclk;
    t_config;
    t_eq;
    t_rx;
    finish_test;
  end
  // The tests take about 300 cycles; 2000 cycles means a hang.
  initial begin
    #20000;
    fails++;
    $display("watchdog expired");
    finish_test;
  end
endmodule : testbench
